// *** dit_timer.sv ***
// Down-counting interval timer with reload, terminal count, capture and masked interrupt
//
// Notes on behaviour
// R1: Counter only decrements, one step per clock edge while counting is allowed.
// R2: Counter at zero loads the period value on the next edge.
// R3: Terminal count is one cycle wide, shown in the reload cycle.
// R4: Counting needs enable active and reset inactive; enable from hardware or software.
// R5: Each qualifying capture edge stores the count exactly once.
// R6: Fixed variant passes capture, reset and enable through two flip-flops.
// R7: Interrupt asserts on any chosen combination of timer events.
// R8: Fabric variant preloads the period value at start, before counting.
// R9: Reset loads the period value and holds it while asserted.
// R10: A reload caused by reset gives no terminal count.
// R11: Disabled at zero postpones the reload and its terminal count; the fixed variant drops that terminal count.
// R12: Fixed variant starts at zero, waits two cycles, then loads without pulse.
// R13: Fixed variant resumes counting two cycles after reset release.
// R14: Fixed variant hardware enable acts two cycles late both ways.
// R15: Fixed variant: enable low just before zero suppresses that terminal count.
// R16: Fabric one-shot hardware enable lags one cycle; continuous mode has no lag.
// R17: Fabric one-shot stops after a period; reset restarts one cycle later.
// R18: Fixed one-shot: first enable low after start freezes until reset or a software stop then start.
// R19: Fixed one-shot: after stop, reset release resumes counting two cycles later.
// R20: Fixed one-shot: software stop then start continues without reload.
// R21: Fabric capture FIFO is four deep per byte; reader drains in time.
// R22: Capture into a full FIFO overwrites the oldest entry.
// R23: Terminal count and capture flags stick until status read; FIFO flags live.
// R24: Interrupt is OR of event sources, each gated by its mask bit.
// R25: Counter width is a parameter: 8 to 32 fabric, 8 or 16 fixed.
module dit_timer
  import dit_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter dit_variant_e VARIANT = DIT_FABRIC
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire dit_ctrl_s ctrl,
  input wire dit_mask_s mask,
  input wire logic [CNT_W-1:0] period,
  input wire logic hwEnable,
  input wire logic hwReset,
  input wire logic captureIn,
  input wire logic statusRead,
  input wire logic captureRead,
  input wire logic captureClear,
  output logic terminalCount,
  output logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] captureData,
  output dit_status_s status,
  output logic irq
);

  localparam bit FIXED = (VARIANT == DIT_FIXED);
  localparam int DEPTH = FIXED ? DIT_DEPTH_FIXED : DIT_DEPTH_FABRIC;
  localparam logic [1:0] INIT_WAIT = FIXED ? DIT_INIT_WAIT_FIXED : DIT_INIT_WAIT_FABRIC;
  // Fixed variant: a disable seen this close to zero drops that period's pulse
  localparam logic [CNT_W-1:0] GUARD = CNT_W'(DIT_GUARD_FIXED);

  // R25 legal widths
  // Whole bytes from 8 to 32 bits, and at most 16 for the fixed variant.
  // Nothing traps another width: the capture lanes assume whole bytes,
  // so a stray width loses its top bits in the store. The parent must choose.

  dit_state_e state;
  dit_state_e next_state;
  logic [CNT_W-1:0] next_count;
  logic [1:0] hold;
  logic [1:0] next_hold;
  logic suppress;
  logic next_suppress;
  logic begun;
  logic next_begun;
  logic swStopped;
  logic next_swStopped;
  logic hwEnDly;
  logic capPrev;
  logic stTc;
  logic stCap;
  logic next_stTc;
  logic next_stCap;
  logic tcPulse;
  logic hwEnEff;
  logic rstEff;
  logic capEff;
  logic enEff;
  logic capEdge;
  logic fifoFull;
  logic fifoNotEmpty;
  logic [1:0] resumeHold;

  // R6 double synchronised inputs
  if (FIXED)
  begin : gSync
    logic [2:0] synced;

    // Costs two cycles on every pin input; software controls are not delayed
    dit_sync #(.N(3)) uSync (
      .mclk(mclk),
      .arst_n(arst_n),
      .async({captureIn, hwReset, hwEnable}),
      .synced(synced)
    );
    // R14 two-cycle enable lag
    assign hwEnEff = synced[0];
    assign rstEff = synced[1];
    assign capEff = synced[2];
  end
  else
  begin : gDirect
    // R16 lag only in one-shot
    assign hwEnEff = ctrl.oneShot ? hwEnDly : hwEnable;
    assign rstEff = hwReset;
    assign capEff = captureIn;
  end

  // A source that the mode ignores counts as permanently high
  // R4 enable source selection
  always_comb
  begin
    enEff = 1'b1;
    if (ctrl.enableMode != DIT_EN_HW_ONLY)
      enEff = enEff && ctrl.swEnable;
    if (ctrl.enableMode != DIT_EN_SW_ONLY)
      enEff = enEff && hwEnEff;
  end

  // Cycles to wait after a reset release before the first decrement
  // R13 R17 R19 release lag
  always_comb
  begin
    if (FIXED)
      resumeHold = DIT_RESUME_FIXED;
    else if (ctrl.oneShot)
      resumeHold = DIT_RESUME_FABRIC_OS;
    else
      resumeHold = DIT_RESUME_NONE;
  end

  // Reset outranks every state, so a held reset pins the count at the period
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_hold = (hold != 2'h0) ? hold - 1'b1 : 2'h0;
    next_suppress = suppress;
    next_begun = begun;
    next_swStopped = swStopped;
    tcPulse = 1'b0;
    if (rstEff)
    begin
      // R9 R10 reset reload, no pulse
      next_count = period;
      next_hold = resumeHold;
      next_state = DIT_ST_RUN;
      next_suppress = 1'b0;
      next_begun = 1'b0;
      next_swStopped = 1'b0;
    end
    else
    begin
      unique case (state)
        DIT_ST_INIT:
        begin
          // R8 R12 initial load, no pulse
          if (hold == 2'h0)
          begin
            next_count = period;
            next_state = DIT_ST_RUN;
          end
        end
        DIT_ST_RUN:
        begin
          if (hold == 2'h0)
          begin
            if (FIXED && ctrl.oneShot && begun && !enEff)
            begin
              // R18 freeze at first disable
              next_state = DIT_ST_HALT;
            end
            else if (enEff && count == '0)
            begin
              // R2 R3 R11 reload with pulse
              next_count = period;
              tcPulse = !suppress;
              next_suppress = 1'b0;
              // R17 one period then stop
              if (ctrl.oneShot)
                next_state = DIT_ST_HALT;
            end
            else if (enEff)
            begin
              // R1 decrement only
              next_count = count - 1'b1;
              next_begun = 1'b1;
            end
            // The flag survives until the reload that it silences
            // R15 late disable drops pulse
            if (FIXED && !enEff && count <= GUARD)
              next_suppress = 1'b1;
          end
        end
        DIT_ST_HALT:
        begin
          // Leaving the halt this way keeps the frozen count
          // R20 software restart keeps count
          if (FIXED && ctrl.oneShot)
          begin
            if (!ctrl.swEnable)
              next_swStopped = 1'b1;
            else if (swStopped)
            begin
              next_state = DIT_ST_RUN;
              next_begun = 1'b0;
              next_swStopped = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // R5 one capture per edge
  always_comb
  begin
    if (FIXED)
      capEdge = (ctrl.captureMode != DIT_CAP_NONE) && capEff && !capPrev;
    else
    begin
      unique case (ctrl.captureMode)
        DIT_CAP_NONE: capEdge = 1'b0;
        DIT_CAP_RISE: capEdge = capEff && !capPrev;
        DIT_CAP_FALL: capEdge = !capEff && capPrev;
        DIT_CAP_BOTH: capEdge = capEff != capPrev;
      endcase
    end
  end

  // R23 sticky flags, set beats clear
  always_comb
  begin
    next_stTc = (stTc && !statusRead) || tcPulse;
    next_stCap = (stCap && !statusRead) || capEdge;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= DIT_ST_INIT;
      count <= '0;
      hold <= INIT_WAIT;
      suppress <= 1'b0;
      begun <= 1'b0;
      swStopped <= 1'b0;
      hwEnDly <= 1'b0;
      capPrev <= 1'b0;
      terminalCount <= 1'b0;
      stTc <= 1'b0;
      stCap <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      hold <= next_hold;
      suppress <= next_suppress;
      begun <= next_begun;
      swStopped <= next_swStopped;
      // One flop of lag for the fabric one-shot enable; unused by the fixed variant
      hwEnDly <= hwEnable;
      capPrev <= capEff;
      // R3 registered single-cycle pulse
      terminalCount <= tcPulse;
      stTc <= next_stTc;
      stCap <= next_stCap;
    end
  end

  // Fabric keeps four captures; the fixed variant a single capture register
  dit_capture_fifo #(.W(CNT_W), .DEPTH(DEPTH)) uFifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .push(capEdge),
    .pushData(count),
    .pop(captureRead),
    .clear(captureClear),
    .headData(captureData),
    .full(fifoFull),
    .notEmpty(fifoNotEmpty)
  );

  // FIFO flags are live, the two event flags sticky
  always_comb
  begin
    status.fifoNotEmpty = fifoNotEmpty;
    status.fifoFull = fifoFull;
    status.capture = stCap;
    status.tc = stTc;
  end

  // Built from registered flags only, so the request never glitches on a pin
  // R7 R24 masked OR of events
  assign irq = (mask.tc && stTc) || (mask.capture && stCap) || (mask.fifoFull && fifoFull);

endmodule

// *** dit_pkg.sv ***
// Shared constants, modes and carriers of the down-counting interval timer
package dit_pkg;

  localparam int DIT_BYTE_W = 8;
  localparam int DIT_DEPTH_FABRIC = 4;
  localparam int DIT_DEPTH_FIXED = 1;
  localparam logic [1:0] DIT_INIT_WAIT_FIXED = 2'h2;
  localparam logic [1:0] DIT_INIT_WAIT_FABRIC = 2'h0;
  localparam logic [1:0] DIT_RESUME_FIXED = 2'h2;
  localparam logic [1:0] DIT_RESUME_FABRIC_OS = 2'h1;
  localparam logic [1:0] DIT_RESUME_NONE = 2'h0;
  localparam int DIT_GUARD_FIXED = 2;

  typedef enum logic
  {
    DIT_FABRIC = 1'b0,
    DIT_FIXED = 1'b1
  } dit_variant_e;

  typedef enum logic [1:0]
  {
    DIT_EN_SW_ONLY = 2'h0,
    DIT_EN_HW_ONLY = 2'h1,
    DIT_EN_SW_AND_HW = 2'h2
  } dit_enmode_e;

  typedef enum logic [1:0]
  {
    DIT_CAP_NONE = 2'h0,
    DIT_CAP_RISE = 2'h1,
    DIT_CAP_FALL = 2'h2,
    DIT_CAP_BOTH = 2'h3
  } dit_capmode_e;

  typedef enum logic [2:0]
  {
    DIT_ST_INIT = 3'h1,
    DIT_ST_RUN = 3'h2,
    DIT_ST_HALT = 3'h4
  } dit_state_e;

  typedef struct packed
  {
    logic oneShot;
    dit_enmode_e enableMode;
    dit_capmode_e captureMode;
    logic swEnable;
  } dit_ctrl_s;

  typedef struct packed
  {
    logic fifoNotEmpty;
    logic fifoFull;
    logic capture;
    logic tc;
  } dit_status_s;

  typedef struct packed
  {
    logic fifoFull;
    logic capture;
    logic tc;
  } dit_mask_s;

endpackage

// *** dit_sync.sv ***
// Two-stage synchroniser for a group of level inputs
module dit_sync
  import dit_pkg::*;
#(
  parameter int N = 3
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [N-1:0] async,
  output logic [N-1:0] synced
);

  logic [N-1:0] stage1;
  logic [N-1:0] next_stage1;
  logic [N-1:0] next_synced;

  always_comb
  begin
    next_stage1 = async;
    next_synced = stage1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= '0;
      synced <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      synced <= next_synced;
    end
  end

endmodule

// *** dit_capture_fifo.sv ***
// Capture store: one FIFO per byte lane sharing pointers, oldest overwritten when full
module dit_capture_fifo
  import dit_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 4
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic push,
  input wire logic [W-1:0] pushData,
  input wire logic pop,
  input wire logic clear,
  output logic [W-1:0] headData,
  output logic full,
  output logic notEmpty
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LANES = W / DIT_BYTE_W;
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] FULLCNT = (PTR_W + 1)'(DEPTH);

  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0] used;
  logic [PTR_W-1:0] next_wrPtr;
  logic [PTR_W-1:0] next_rdPtr;
  logic [PTR_W:0] next_used;
  logic doPop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign full = (used == FULLCNT);
  assign notEmpty = (used != '0);

  always_comb
  begin
    doPop = pop && notEmpty;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_used = used;
    if (clear)
    begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_used = '0;
    end
    else
    begin
      if (push)
        next_wrPtr = bump(wrPtr);
      // R22 overwrite oldest
      if (doPop || (push && full))
        next_rdPtr = bump(rdPtr);
      if (push && !full && !doPop)
        next_used = used + 1'b1;
      else if (doPop && !push)
        next_used = used - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      used <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      used <= next_used;
    end
  end

  // R21 all byte lanes captured together
  for (genvar g = 0; g < LANES; g++)
  begin : gLane
    logic [DIT_BYTE_W-1:0] mem [DEPTH];

    always_ff @(posedge mclk)
    begin
      if (push && !clear)
        mem[wrPtr] <= pushData[g*DIT_BYTE_W +: DIT_BYTE_W];
    end

    assign headData[g*DIT_BYTE_W +: DIT_BYTE_W] = mem[rdPtr];
  end

endmodule

// *** dit_timer_monitor.sv ***
// Port-level assertions for the interval timer
module dit_timer_monitor
  import dit_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter dit_variant_e VARIANT = DIT_FABRIC
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire dit_ctrl_s ctrl,
  input wire dit_mask_s mask,
  input wire logic [CNT_W-1:0] period,
  input wire logic hwReset,
  input wire logic captureIn,
  input wire logic captureClear,
  input wire logic statusRead,
  input wire logic terminalCount,
  input wire logic [CNT_W-1:0] count,
  input wire dit_status_s status,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Fixed variant sees inputs two flops late, so raw-timing checks are fabric only
  logic fab;
  assign fab = (VARIANT == DIT_FABRIC);
  logic swOff;
  assign swOff = (ctrl.enableMode != DIT_EN_HW_ONLY) && !ctrl.swEnable;

  sequence capEdge;
    fab && ctrl.captureMode == DIT_CAP_RISE && $rose(captureIn) && !captureClear;
  endsequence
  sequence capStored;
    status.capture && status.fifoNotEmpty;
  endsequence

  a_tc_single: assert property (terminalCount |=> !terminalCount)
    else $error("tc pulse too long");
  a_tc_reload: assert property (terminalCount |-> count == period && $past(count) == 0)
    else $error("tc without reload from zero");
  a_count_down: assert property (fab && !$past(hwReset) && $past(count) != 0 && count != $past(count)
    |-> count == $past(count) - 1)
    else $error("count moved other than down by one");
  a_reset_loads: assert property (fab && hwReset |=> count == period)
    else $error("reset did not load period");
  a_reset_no_tc: assert property (fab && hwReset |=> !terminalCount)
    else $error("tc on reset reload");
  a_zero_wait: assert property (swOff && count == 0 |=> !terminalCount)
    else $error("reload while disabled");
  a_hold_off: assert property (fab && swOff && !hwReset && count != 0 |=> $stable(count))
    else $error("count moved while disabled");
  a_tc_sticky: assert property (terminalCount |-> status.tc)
    else $error("tc flag not set");
  a_flag_holds: assert property (status.tc && !statusRead |=> status.tc)
    else $error("tc flag dropped");
  a_read_clears: assert property (statusRead |=> status.tc == terminalCount)
    else $error("tc flag not cleared");
  a_cap_store: assert property (capEdge |=> capStored)
    else $error("capture not stored");
  a_irq_or: assert property (irq == ((status.tc && mask.tc) || (status.capture && mask.capture)
    || (status.fifoFull && mask.fifoFull)))
    else $error("irq not masked OR");
endmodule

bind dit_timer dit_timer_monitor #(.CNT_W(CNT_W), .VARIANT(VARIANT)) i_dit_timer_monitor (.mclk(mclk),
  .arst_n(arst_n), .ctrl(ctrl), .mask(mask), .period(period), .hwReset(hwReset), .captureIn(captureIn),
  .captureClear(captureClear), .statusRead(statusRead), .terminalCount(terminalCount), .count(count),
  .status(status), .irq(irq));

// *** dit_neighbour.sv ***
// Neighbouring logic: raises capture edges and pops the capture store
module dit_neighbour
(
  input wire logic mclk,
  input wire logic [7:0] count,
  output logic captureIn,
  output logic captureRead
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    captureIn = 1'b0;
    captureRead = 1'b0;
  end
  task automatic capPulse(input int w, output logic [7:0] v);
    @(posedge mclk);
    captureIn <= 1'b1;
    @(negedge mclk);
    v = count;
    repeat (w) @(posedge mclk);
    captureIn <= 1'b0;
  endtask
  task automatic popHead;
    @(posedge mclk);
    captureRead <= 1'b1;
    @(posedge mclk);
    captureRead <= 1'b0;
  endtask
endmodule

// *** test_dit_timer.sv ***
// Self-checking bench for the fabric interval timer, with start-up checks of the fixed variant
module test_dit_timer
  import dit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, arst_n, hwEnable, hwReset, statusRead, captureClear, captureIn, captureRead;
  logic terminalCount, irq;
  logic fTc;
  logic [7:0] fCount;
  logic [7:0] period, count, captureData, v;
  dit_ctrl_s ctrl;
  dit_mask_s mask;
  dit_status_s status;
  logic [7:0] capQ[$];
  int nErrors = 0;
  int checksDone = 0;

  dit_timer #(.CNT_W(8), .VARIANT(DIT_FABRIC)) i_dit_timer (.mclk(mclk), .arst_n(arst_n), .ctrl(ctrl),
    .mask(mask), .period(period), .hwEnable(hwEnable), .hwReset(hwReset), .captureIn(captureIn),
    .statusRead(statusRead), .captureRead(captureRead), .captureClear(captureClear),
    .terminalCount(terminalCount), .count(count), .captureData(captureData), .status(status), .irq(irq));
  dit_timer #(.CNT_W(8), .VARIANT(DIT_FIXED)) i_dit_timer_fixed (.mclk(mclk), .arst_n(arst_n), .ctrl(ctrl),
    .mask(mask), .period(period), .hwEnable(hwEnable), .hwReset(hwReset), .captureIn(captureIn),
    .statusRead(statusRead), .captureRead(captureRead), .captureClear(captureClear),
    .terminalCount(fTc), .count(fCount), .captureData(), .status(), .irq());
  dit_neighbour i_dit_neighbour (.mclk(mclk), .count(count), .captureIn(captureIn), .captureRead(captureRead));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input logic [7:0] c, input logic t);
    @(negedge mclk);
    chk(count, c);
    chk(terminalCount, t);
  endtask

  task automatic results;
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    arst_n = 1'b0;
    ctrl = {1'b0, DIT_EN_SW_ONLY, DIT_CAP_RISE, 1'b0};
    mask = 3'h7;
    period = 8'h03;
    hwEnable = 1'b0;
    hwReset = 1'b0;
    statusRead = 1'b0;
    captureClear = 1'b0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    tick(8'h03, 1'b0);
    chk(fCount, 8'h00);
    tick(8'h03, 1'b0);
    chk(fCount, 8'h00);
    @(posedge mclk) ctrl.swEnable <= 1'b1;
    tick(8'h03, 1'b0);
    chk(fCount, 8'h03);
    chk(fTc, 1'b0);
    for (int i = 1; i <= 10; i++)
      tick(8'((19 - i) % 4), i % 4 == 0);
    // Disable lands on the edge that reaches zero
    @(posedge mclk) ctrl.swEnable <= 1'b0;
    repeat (3) tick(8'h00, 1'b0);
    @(posedge mclk) ctrl.swEnable <= 1'b1;
    tick(8'h00, 1'b0);
    tick(8'h03, 1'b1);
    tick(8'h02, 1'b0);
    tick(8'h01, 1'b0);
    @(posedge mclk) hwReset <= 1'b1;
    tick(8'h00, 1'b0);
    tick(8'h03, 1'b0);
    @(posedge mclk) hwReset <= 1'b0;
    tick(8'h03, 1'b0);
    tick(8'h02, 1'b0);
    for (int i = 1; i <= 5; i++)
    begin
      i_dit_neighbour.capPulse(i, v);
      if (capQ.size() == 4)
        void'(capQ.pop_front());
      capQ.push_back(v);
    end
    @(negedge mclk);
    chk(status.fifoFull, 1'b1);
    @(posedge mclk) ctrl.swEnable <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      chk(captureData, capQ.pop_front());
      i_dit_neighbour.popHead();
    end
    @(negedge mclk);
    chk(status.fifoNotEmpty, 1'b0);
    chk(status.capture, 1'b1);
    @(posedge mclk) statusRead <= 1'b1;
    @(posedge mclk) statusRead <= 1'b0;
    @(negedge mclk);
    chk(status.capture, 1'b0);
    chk(status.tc, 1'b0);
    i_dit_neighbour.capPulse(1, v);
    @(posedge mclk) mask <= 3'h0;
    @(negedge mclk) chk(irq, 1'b0);
    @(posedge mclk) mask <= 3'h2;
    @(negedge mclk) chk(irq, 1'b1);
    @(posedge mclk) mask <= 3'h5;
    @(negedge mclk) chk(irq, 1'b0);
    @(posedge mclk) captureClear <= 1'b1;
    @(posedge mclk) captureClear <= 1'b0;
    @(negedge mclk) chk(status.fifoNotEmpty, 1'b0);
    @(posedge mclk);
    ctrl <= {1'b1, DIT_EN_HW_ONLY, DIT_CAP_RISE, 1'b1};
    hwEnable <= 1'b1;
    hwReset <= 1'b1;
    repeat (2) @(posedge mclk);
    hwReset <= 1'b0;
    tick(8'h03, 1'b0);
    tick(8'h03, 1'b0);
    tick(8'h02, 1'b0);
    tick(8'h01, 1'b0);
    tick(8'h00, 1'b0);
    tick(8'h03, 1'b1);
    repeat (3) tick(8'h03, 1'b0);
    results();
  end
endmodule
